// [dffs_checker.sv]
// concurrent checks on the status flag ports of the fifo block
`timescale 1ns/1ps
module dffs_checker
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// clock pins, master reset and write handshake
	input wire logic wr_clk_pin,
	input wire logic rd_clk_pin,
	input wire logic master_reset,
	input wire logic wr_valid,
	input wire logic wr_ready,
	// status flags, active low
	input wire logic empty_flag,
	input wire logic full_flag,
	input wire logic output_ready,
	input wire logic input_ready,
	input wire logic almost_empty_flag,
	input wire logic almost_full_flag,
	input wire logic half_full_flag
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	logic       wr_q;
	logic       rd_q;
	logic [3:0] wr_age;
	logic [3:0] rd_age;
	// cycles since each clock pin last rose, saturating at 15
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			wr_q   <= 1'b0;
			rd_q   <= 1'b0;
			wr_age <= 4'hf;
			rd_age <= 4'hf;
		end
		else
		begin
			wr_q   <= wr_clk_pin;
			rd_q   <= rd_clk_pin;
			wr_age <= (wr_clk_pin && !wr_q) ? 4'h0 : wr_age + {3'h0, wr_age != 4'hf};
			rd_age <= (rd_clk_pin && !rd_q) ? 4'h0 : rd_age + {3'h0, rd_age != 4'hf};
		end
	end
	mr_flags_a: assert property (master_reset[*8] |-> {empty_flag, full_flag, output_ready,
		input_ready, almost_empty_flag, almost_full_flag, half_full_flag} == 7'h33)
		else $error("flags not at reset values under master reset");
	flag_excl_a: assert property (empty_flag || full_flag)
		else $error("empty and full both asserted");
	ready_excl_a: assert property (!(output_ready && input_ready))
		else $error("output ready and input ready both flag trouble");
	full_pair_a: assert property ($fell(full_flag) |-> ##[0:2]
		(!almost_full_flag && !half_full_flag)) else $error("full without almost full");
	ir_pair_a: assert property ($rose(input_ready) |-> ##[0:2]
		(!almost_full_flag && !half_full_flag)) else $error("input ready without almost full");
	ef_pae_a: assert property ($fell(empty_flag) |-> ##[0:2] !almost_empty_flag)
		else $error("empty without almost empty");
	or_rdclk_a: assert property ($fell(output_ready) |-> rd_age < 4'h8)
		else $error("output ready moved away from a read clock edge");
	ef_rdclk_a: assert property ($rose(empty_flag) |-> rd_age < 4'h8)
		else $error("empty flag lifted away from a read clock edge");
	ir_wrclk_a: assert property ($rose(input_ready) |-> wr_age < 4'h8)
		else $error("input ready moved away from a write clock edge");
	wr_ready_a: assert property ($fell(wr_ready) |-> $past(wr_valid))
		else $error("write buffer closed without a word offered");
endmodule : dffs_checker

bind dffs_top dffs_checker u_chk (.sys_clk, .rst, .wr_clk_pin, .rd_clk_pin, .master_reset,
	.wr_valid, .wr_ready, .empty_flag, .full_flag, .output_ready, .input_ready,
	.almost_empty_flag, .almost_full_flag, .half_full_flag);

// [dffs_defs.svh]
// named constants for the deep fifo status flag block
`ifndef DFFS_DEFS_SVH
`define DFFS_DEFS_SVH

`define DFFS_DATA_W       36
`define DFFS_OFS_W        16
`define DFFS_SER_BITS     32
`define DFFS_SER_CNT_W    6
`define DFFS_BIG_DEPTH    2048

// synchronised pin positions
`define DFFS_PIN_N        8
`define DFFS_PIN_WCLK     0
`define DFFS_PIN_RCLK     1
`define DFFS_PIN_MRS      2
`define DFFS_PIN_FWFT     3
`define DFFS_PIN_LD       4
`define DFFS_PIN_PICK0    5
`define DFFS_PIN_PICK1    6
`define DFFS_PIN_PFM      7

// default offset exponents, index {load_select, pick1, pick0}, small depths
`define DFFS_SEL_LLL      3'h0
`define DFFS_SEL_LLH      3'h1
`define DFFS_SEL_LHL      3'h2
`define DFFS_SEL_LHH      3'h3
`define DFFS_SEL_HLL      3'h4
`define DFFS_SEL_HLH      3'h5
`define DFFS_SEL_HHL      3'h6
`define DFFS_EXP_LLL      5'h06
`define DFFS_EXP_LLH      5'h08
`define DFFS_EXP_LHL      5'h07
`define DFFS_EXP_LHH      5'h02
`define DFFS_EXP_HLL      5'h09
`define DFFS_EXP_HLH      5'h05
`define DFFS_EXP_HHL      5'h04
`define DFFS_EXP_HHH      5'h03

// offset readback word layout on data_out
`define DFFS_RB_EMPTY_LSB 0
`define DFFS_RB_FULL_LSB  18

// flag and register values after reset (flags are active low)
`define DFFS_EF_RST       1'b0
`define DFFS_FF_RST       1'b1
`define DFFS_OR_RST       1'b1
`define DFFS_IR_RST       1'b0
`define DFFS_AE_RST       1'b0
`define DFFS_AF_RST       1'b1
`define DFFS_HF_RST       1'b1
`define DFFS_OFS_RST      16'h0000

`endif

// [dffs_far_clocks.sv]
// writer and reader clock pins on free-running, unrelated timebases
`timescale 1ns/1ps
module dffs_far_clocks
#(
	parameter int WR_HALF = 97,
	parameter int RD_HALF = 107
)
(
	// clock pins toward the block
	output logic wr_clk_pin,
	output logic rd_clk_pin
);
	// independent clocks, any ratio allowed between them
	initial
	begin
		wr_clk_pin = 1'b0;
		forever #(WR_HALF) wr_clk_pin = ~wr_clk_pin;
	end
	initial
	begin
		rd_clk_pin = 1'b0;
		#3;
		forever #(RD_HALF) rd_clk_pin = ~rd_clk_pin;
	end
endmodule : dffs_far_clocks

// [dffs_pin_sync.sv]
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module dffs_pin_sync
(
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// pin in, filtered level out
	input  wire logic pin,
	output logic      level
);
	logic s1;
	logic s2;
	logic s3;

	// three flops; level follows once the second and third agree
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			s1    <= 1'b0;
			s2    <= 1'b0;
			s3    <= 1'b0;
			level <= 1'b0;
		end
		else
		begin
			s1 <= pin;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3)
				level <= s3;
		end
	end

endmodule : dffs_pin_sync

// [dffs_pkg.sv]
// types shared by the deep fifo status flag block
package dffs_pkg;

	typedef enum logic [1:0]
	{
		DFFS_MODE_STD  = 2'b01,
		DFFS_MODE_FWFT = 2'b10
	} dffs_mode_t;

	typedef enum logic [1:0]
	{
		DFFS_PROG_PAR = 2'b01,
		DFFS_PROG_SER = 2'b10
	} dffs_prog_t;

endpackage : dffs_pkg

// [dffs_skid.sv]
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module dffs_skid
#(
	parameter int W = 36
)
(
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// filling side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// draining side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	logic [W-1:0] slot0;
	logic [W-1:0] slot1;
	logic [1:0]   cnt;
	logic [1:0]   next_cnt;
	logic         push;
	logic         pop;

	// handshakes and occupancy
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign out_valid = (cnt != 2'h0);
	assign out_data  = slot0;
	assign next_cnt  = cnt + {1'b0, push} - {1'b0, pop};

	// occupancy and registered ready toward the source
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cnt      <= 2'h0;
			in_ready <= 1'b1;
		end
		else
		begin
			cnt      <= next_cnt;
			in_ready <= (next_cnt != 2'h2);
		end
	end

	// slot storage, head always in slot0
	always_ff @(posedge clk)
	begin
		if (push && !pop)
		begin
			if (cnt == 2'h0)
				slot0 <= in_data;
			else
				slot1 <= in_data;
		end
		else if (pop && !push)
			slot0 <= slot1;
		else if (push && pop)
		begin
			if (cnt == 2'h1)
				slot0 <= in_data;
			else
			begin
				slot0 <= slot1;
				slot1 <= in_data;
			end
		end
	end

endmodule : dffs_skid

// [dffs_top.sv]
// deep fifo with status flags and offset programming
//
// What this block does
// - timing mode latched from pin at master reset
// - standard mode reads need requests; empty lifts
// - fall-through shows first word after three edges
// - fall-through almost-empty high at n+2 words
// - fall-through half-full low at depth/2+2
// - fall-through almost-full low at depth+1-m
// - fall-through input ready high at depth+1
// - fall-through reads from full release flags
// - fall-through almost-empty low at n+1 words
// - fall-through output ready high once drained
// - output ready three stages, input ready one
// - standard almost-empty high at n+1 words
// - standard half-full low at depth/2+1
// - standard almost-full low at depth-m
// - standard full low at depth words
// - standard almost-empty low at n words
// - standard empty low after last read
// - standard empty and full are registered
// - master reset loads one of eight defaults
// - load select picks serial or parallel programming
// - offsets read back on parallel data outputs
// - offsets programmable any time after reset
// - synchronous almost flags update on own clock
// - asynchronous almost-full set write, cleared read
`timescale 1ns/1ps
`include "dffs_defs.svh"
module dffs_top
	import dffs_pkg::*;
#(
	parameter int DEPTH = 1024
)
(
	// clock and reset
	input  wire logic                     sys_clk,
	input  wire logic                     rst,
	// device pins sampled through synchronisers
	input  wire logic                     wr_clk_pin,
	input  wire logic                     rd_clk_pin,
	input  wire logic                     master_reset,
	input  wire logic                     fallthrough_or_serial_in,
	input  wire logic                     offset_load_select,
	input  wire logic                     offset_default_pick0,
	input  wire logic                     offset_default_pick1,
	input  wire logic                     almost_flag_sync_select,
	// write stream
	input  wire logic                     wr_valid,
	output logic                          wr_ready,
	input  wire logic [`DFFS_DATA_W-1:0]  wr_data,
	// read side
	input  wire logic                     rd_req,
	output logic [`DFFS_DATA_W-1:0]       data_out,
	// offset programming and readback
	input  wire logic                     ofs_write_empty,
	input  wire logic                     ofs_write_full,
	input  wire logic [`DFFS_OFS_W-1:0]   ofs_data,
	input  wire logic                     ofs_serial_shift,
	input  wire logic                     ofs_readback,
	// status flags, active low
	output logic                          empty_flag,
	output logic                          full_flag,
	output logic                          output_ready,
	output logic                          input_ready,
	output logic                          almost_empty_flag,
	output logic                          almost_full_flag,
	output logic                          half_full_flag
);
	localparam int AW = $clog2(DEPTH);
	localparam int PW = AW + 2;
	localparam int CW = PW + 1;
	localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
	localparam logic [CW-1:0] HALF_C  = CW'(DEPTH / 2);
	localparam logic BIG = (DEPTH > `DFFS_BIG_DEPTH);

	// default offset for a strap pattern, one step larger for deep parts
	function automatic logic [`DFFS_OFS_W-1:0] default_offset(input logic [2:0] sel,
		input logic big);
		logic [4:0] e;
		e = `DFFS_EXP_HHH;
		case (sel)
			`DFFS_SEL_LLL: e = `DFFS_EXP_LLL;
			`DFFS_SEL_LLH: e = `DFFS_EXP_LLH;
			`DFFS_SEL_LHL: e = `DFFS_EXP_LHL;
			`DFFS_SEL_LHH: e = `DFFS_EXP_LHH;
			`DFFS_SEL_HLL: e = `DFFS_EXP_HLL;
			`DFFS_SEL_HLH: e = `DFFS_EXP_HLH;
			`DFFS_SEL_HHL: e = `DFFS_EXP_HHL;
			default:       e = `DFFS_EXP_HHH;
		endcase
		if (big)
			e = e + 5'h01;
		return `DFFS_OFS_W'((32'h1 << e) - 32'h1);
	endfunction : default_offset

	// word count between two pointers, widened for threshold compares
	function automatic logic [CW-1:0] level(input logic [PW-1:0] a, input logic [PW-1:0] b);
		logic [PW-1:0] d;
		d = a - b;
		return {1'b0, d};
	endfunction : level

	// pin synchronisers
	logic [`DFFS_PIN_N-1:0] pin_raw;
	logic [`DFFS_PIN_N-1:0] pin_sync;
	assign pin_raw[`DFFS_PIN_WCLK]  = wr_clk_pin;
	assign pin_raw[`DFFS_PIN_RCLK]  = rd_clk_pin;
	assign pin_raw[`DFFS_PIN_MRS]   = master_reset;
	assign pin_raw[`DFFS_PIN_FWFT]  = fallthrough_or_serial_in;
	assign pin_raw[`DFFS_PIN_LD]    = offset_load_select;
	assign pin_raw[`DFFS_PIN_PICK0] = offset_default_pick0;
	assign pin_raw[`DFFS_PIN_PICK1] = offset_default_pick1;
	assign pin_raw[`DFFS_PIN_PFM]   = almost_flag_sync_select;

	genvar gi;
	generate
		for (gi = 0; gi < `DFFS_PIN_N; gi++)
		begin : g_pin
			dffs_pin_sync u_sync
			(
				.clk   (sys_clk),
				.rst   (rst),
				.pin   (pin_raw[gi]),
				.level (pin_sync[gi])
			);
		end
	endgenerate

	logic msr;
	assign msr = pin_sync[`DFFS_PIN_MRS];

	// rising edges of the sampled write and read clocks
	logic wclk_prev;
	logic rclk_prev;
	logic wr_tick;
	logic rd_tick;
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			wclk_prev <= 1'b0;
			rclk_prev <= 1'b0;
		end
		else
		begin
			wclk_prev <= pin_sync[`DFFS_PIN_WCLK];
			rclk_prev <= pin_sync[`DFFS_PIN_RCLK];
		end
	end
	assign wr_tick = pin_sync[`DFFS_PIN_WCLK] & ~wclk_prev;
	assign rd_tick = pin_sync[`DFFS_PIN_RCLK] & ~rclk_prev;

	// configuration caught while master reset is held
	dffs_mode_t mode;
	dffs_prog_t prog;
	logic       flag_sync;
	logic       fwft;
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			mode      <= DFFS_MODE_STD;
			prog      <= DFFS_PROG_PAR;
			flag_sync <= 1'b0;
		end
		else if (msr)
		begin
			mode      <= pin_sync[`DFFS_PIN_FWFT] ? DFFS_MODE_FWFT : DFFS_MODE_STD;
			prog      <= pin_sync[`DFFS_PIN_LD] ? DFFS_PROG_SER : DFFS_PROG_PAR;
			flag_sync <= pin_sync[`DFFS_PIN_PFM];
		end
	end
	assign fwft = (mode == DFFS_MODE_FWFT);

	// serial offset shifter, fed from the shared mode/serial pin
	logic [`DFFS_SER_BITS-1:0]  ser_shreg;
	logic [`DFFS_SER_CNT_W-1:0] ser_cnt;
	logic                       ser_done;
	assign ser_done = (ser_cnt == `DFFS_SER_CNT_W'(`DFFS_SER_BITS - 1));
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			ser_shreg <= '0;
			ser_cnt   <= '0;
		end
		else if (msr)
			ser_cnt <= '0;
		else if (ofs_serial_shift && prog == DFFS_PROG_SER)
		begin
			ser_shreg <= {pin_sync[`DFFS_PIN_FWFT], ser_shreg[`DFFS_SER_BITS-1:1]};
			ser_cnt   <= ser_done ? '0 : ser_cnt + 1'b1;
		end
	end

	// empty offset n and full offset m
	logic [`DFFS_OFS_W-1:0] ofs_empty;
	logic [`DFFS_OFS_W-1:0] ofs_full;
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			ofs_empty <= `DFFS_OFS_RST;
			ofs_full  <= `DFFS_OFS_RST;
		end
		else if (msr)
		begin
			ofs_empty <= default_offset({pin_sync[`DFFS_PIN_LD], pin_sync[`DFFS_PIN_PICK1],
				pin_sync[`DFFS_PIN_PICK0]}, BIG);
			ofs_full  <= default_offset({pin_sync[`DFFS_PIN_LD], pin_sync[`DFFS_PIN_PICK1],
				pin_sync[`DFFS_PIN_PICK0]}, BIG);
		end
		else if (prog == DFFS_PROG_SER)
		begin
			if (ofs_serial_shift && ser_done)
			begin
				ofs_empty <= {pin_sync[`DFFS_PIN_FWFT], ser_shreg[`DFFS_SER_BITS-1:17]};
				ofs_full  <= ser_shreg[16:1];
			end
		end
		else
		begin
			if (ofs_write_empty)
				ofs_empty <= ofs_data;
			if (ofs_write_full)
				ofs_full <= ofs_data;
		end
	end

	// write buffer in front of the memory; drains on write clock edges while not full, and while master reset is held
	logic                    buf_valid;
	logic                    buf_take;
	logic [`DFFS_DATA_W-1:0] buf_data;
	dffs_skid #(.W(`DFFS_DATA_W)) u_wbuf
	(
		.clk       (sys_clk),
		.rst       (rst),
		.in_valid  (wr_valid),
		.in_ready  (wr_ready),
		.in_data   (wr_data),
		.out_valid (buf_valid),
		.out_ready (buf_take),
		.out_data  (buf_data)
	);

	// pointers and their staged copies in the other side's view
	logic [PW-1:0] wptr;
	logic [PW-1:0] mptr;
	logic [PW-1:0] cptr;
	logic [PW-1:0] cptr_w;
	logic [PW-1:0] wptr_r1;
	logic [PW-1:0] wptr_r2;
	logic          out_valid;
	logic [`DFFS_DATA_W-1:0] mem [0:2*DEPTH-1];

	// per-edge decisions
	logic          full_now;
	logic          commit;
	logic          mem_has;
	logic          std_read;
	logic          consume;
	logic          load;
	logic          pop;
	logic          next_out_valid;
	logic [PW-1:0] next_wptr;
	logic [PW-1:0] next_cptr;
	logic [CW-1:0] lvl_w;
	logic [CW-1:0] lvl_r;
	logic [CW-1:0] lvl_t;

	assign full_now  = level(wptr, cptr_w) >= DEPTH_C + CW'(fwft);
	// master reset drains queued words so that a new run starts empty
	assign buf_take  = msr | (wr_tick & ~full_now);
	assign commit    = buf_valid & buf_take & ~msr;
	assign mem_has   = (wptr_r2 != mptr);
	assign std_read  = ~fwft & rd_tick & rd_req & mem_has & ~msr;
	assign consume   = fwft & rd_tick & rd_req & out_valid & ~msr;
	assign load      = fwft & rd_tick & mem_has & (~out_valid | rd_req) & ~msr;
	assign pop       = std_read | load;
	assign next_wptr = wptr + PW'(commit);
	assign next_cptr = cptr + PW'(std_read | consume);
	assign next_out_valid = load | (out_valid & ~consume);
	// write view levels use the read pointer unstaged, read view the write pointer one stage late
	assign lvl_w     = level(next_wptr, cptr);
	assign lvl_r     = level(wptr_r1, next_cptr);
	assign lvl_t     = level(next_wptr, next_cptr);

	// pointer registers and cross-view stages
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			wptr      <= '0;
			mptr      <= '0;
			cptr      <= '0;
			cptr_w    <= '0;
			wptr_r1   <= '0;
			wptr_r2   <= '0;
			out_valid <= 1'b0;
		end
		else if (msr)
		begin
			wptr      <= '0;
			mptr      <= '0;
			cptr      <= '0;
			cptr_w    <= '0;
			wptr_r1   <= '0;
			wptr_r2   <= '0;
			out_valid <= 1'b0;
		end
		else
		begin
			wptr      <= next_wptr;
			cptr      <= next_cptr;
			mptr      <= mptr + PW'(pop);
			out_valid <= next_out_valid;
			if (wr_tick)
				cptr_w <= cptr;
			if (rd_tick)
			begin
				wptr_r1 <= wptr;
				wptr_r2 <= wptr_r1;
			end
		end
	end

	// memory write
	always_ff @(posedge sys_clk)
	begin
		if (commit)
			mem[wptr[AW:0]] <= buf_data;
	end

	// data outputs carry words or the offset readback
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			data_out <= '0;
		else if (pop)
			data_out <= mem[mptr[AW:0]];
		else if (ofs_readback)
		begin
			data_out <= '0;
			data_out[`DFFS_RB_EMPTY_LSB +: `DFFS_OFS_W] <= ofs_empty;
			data_out[`DFFS_RB_FULL_LSB +: `DFFS_OFS_W]  <= ofs_full;
		end
	end

	// empty and output ready follow read clock edges
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			empty_flag   <= `DFFS_EF_RST;
			output_ready <= `DFFS_OR_RST;
		end
		else if (msr)
		begin
			empty_flag   <= `DFFS_EF_RST;
			output_ready <= `DFFS_OR_RST;
		end
		else if (rd_tick)
		begin
			if (!fwft)
				empty_flag <= (lvl_r != '0);
			else
				output_ready <= ~next_out_valid;
		end
	end

	// full and input ready follow write clock edges
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			full_flag   <= `DFFS_FF_RST;
			input_ready <= `DFFS_IR_RST;
		end
		else if (msr)
		begin
			full_flag   <= `DFFS_FF_RST;
			input_ready <= `DFFS_IR_RST;
		end
		else if (wr_tick)
		begin
			if (!fwft)
				full_flag <= ~(lvl_w >= DEPTH_C);
			else
				input_ready <= (lvl_w >= DEPTH_C + CW'(1'b1));
		end
	end

	// almost flags: own clock when synchronous, either clock otherwise
	logic          ae_tick;
	logic          af_tick;
	logic [CW-1:0] ae_lvl;
	logic [CW-1:0] af_lvl;
	assign ae_tick = flag_sync ? rd_tick : (rd_tick | wr_tick);
	assign af_tick = flag_sync ? wr_tick : (rd_tick | wr_tick);
	assign ae_lvl  = flag_sync ? lvl_r : lvl_t;
	assign af_lvl  = flag_sync ? lvl_w : lvl_t;

	// threshold compares; fall-through adds one for the output register
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			almost_empty_flag <= `DFFS_AE_RST;
			almost_full_flag  <= `DFFS_AF_RST;
			half_full_flag    <= `DFFS_HF_RST;
		end
		else if (msr)
		begin
			almost_empty_flag <= `DFFS_AE_RST;
			almost_full_flag  <= `DFFS_AF_RST;
			half_full_flag    <= `DFFS_HF_RST;
		end
		else
		begin
			if (ae_tick)
				almost_empty_flag <= ae_lvl > CW'(ofs_empty) + CW'(fwft);
			if (af_tick)
				almost_full_flag <= ~(af_lvl >= DEPTH_C - CW'(ofs_full) + CW'(fwft));
			if (rd_tick | wr_tick)
				half_full_flag <= ~(lvl_t >= HALF_C + CW'(1'b1) + CW'(fwft));
		end
	end

endmodule : dffs_top

// [dffs_top_tb_top.sv]
// self-checking bench for the fifo status flag block
`timescale 1ns/1ps
module dffs_top_tb_top;
	logic sys_clk, wr_clk_pin, rd_clk_pin, wr_ready;
	logic rst = 1'b1, master_reset = 1'b0, fallthrough_or_serial_in = 1'b0;
	logic offset_load_select = 1'b0, offset_default_pick0 = 1'b0, offset_default_pick1 = 1'b0;
	logic almost_flag_sync_select = 1'b0, wr_valid = 1'b0, rd_req = 1'b0;
	logic ofs_write_empty = 1'b0, ofs_write_full = 1'b0, ofs_serial_shift = 1'b0;
	logic ofs_readback = 1'b0;
	logic [35:0] wr_data = 36'h0;
	logic [15:0] ofs_data = 16'h0;
	logic [35:0] data_out;
	logic empty_flag, full_flag, output_ready, input_ready;
	logic almost_empty_flag, almost_full_flag, half_full_flag;
	int err_total = 0;
	int samples_checked = 0;
	int wcnt = 0;
	wire logic [35:0] flg = {29'h0, empty_flag, full_flag, output_ready, input_ready,
		almost_empty_flag, almost_full_flag, half_full_flag};
	logic [15:0] dv [8] = '{16'h003f, 16'h00ff, 16'h007f, 16'h0003,
		16'h01ff, 16'h001f, 16'h000f, 16'h0007};

	// block under test and its far-side clocks
	dffs_top #(.DEPTH(1024)) DUT (.sys_clk, .rst, .wr_clk_pin, .rd_clk_pin, .master_reset,
		.fallthrough_or_serial_in, .offset_load_select, .offset_default_pick0,
		.offset_default_pick1, .almost_flag_sync_select, .wr_valid, .wr_ready, .wr_data,
		.rd_req, .data_out, .ofs_write_empty, .ofs_write_full, .ofs_data, .ofs_serial_shift,
		.ofs_readback, .empty_flag, .full_flag, .output_ready, .input_ready,
		.almost_empty_flag, .almost_full_flag, .half_full_flag);
	dffs_far_clocks far (.wr_clk_pin, .rd_clk_pin);

	// 50 MHz system clock
	initial
	begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	task automatic tick(input int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask : tick

	function automatic logic [35:0] wd(input int i);
		return 36'h500000000 + 36'(i);
	endfunction : wd

	task automatic chk(input string what, input logic [35:0] seen, input logic [35:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic give_verdict();
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : give_verdict

	// straps held through a long master reset, then released
	task automatic mreset(input logic ft, ld, p1, p0, sy);
		fallthrough_or_serial_in = ft;
		offset_load_select = ld;
		offset_default_pick1 = p1;
		offset_default_pick0 = p0;
		almost_flag_sync_select = sy;
		master_reset = 1'b1;
		tick(10);
		master_reset = 1'b0;
		tick(8);
		wcnt = 0;
	endtask : mreset

	// parallel offset load, values kept inside 0 to depth-1
	task automatic prog(input logic [15:0] n, m);
		ofs_data = n;
		ofs_write_empty = 1'b1;
		tick(1);
		ofs_write_empty = 1'b0;
		ofs_data = m;
		ofs_write_full = 1'b1;
		tick(1);
		ofs_write_full = 1'b0;
	endtask : prog

	task automatic rdback(input logic [15:0] n, m);
		ofs_readback = 1'b1;
		tick(1);
		ofs_readback = 1'b0;
		tick(2);
		chk("offsets", data_out, {2'h0, m, 2'h0, n});
	endtask : rdback

	// offer k words back to back, then let both sides settle
	task automatic fill(input int k);
		repeat (k)
		begin
			wr_data = wd(wcnt);
			wr_valid = 1'b1;
			for (int j = 0; j < 100 && wr_ready !== 1'b1; j++)
				tick(1);
			tick(1);
			wcnt++;
		end
		wr_valid = 1'b0;
		tick(80);
	endtask : fill

	// one read request held across exactly one read clock edge
	task automatic rd1();
		@(posedge rd_clk_pin);
		tick(7);
		rd_req = 1'b1;
		@(posedge rd_clk_pin);
		tick(7);
		rd_req = 1'b0;
		tick(60);
	endtask : rd1

	// defaults, then serial load while serial mode is latched, then parallel
	task automatic sc_defaults();
		logic [31:0] sw = 32'h01230234;
		for (int c = 0; c < 8; c++)
		begin
			mreset(1'b0, c[2], c[1], c[0], 1'b0);
			rdback(dv[c], dv[c]);
		end
		prog(16'h0011, 16'h0022);
		rdback(16'h0007, 16'h0007);
		for (int b = 0; b < 32; b++)
		begin
			fallthrough_or_serial_in = sw[b];
			tick(5);
			ofs_serial_shift = 1'b1;
			tick(1);
			ofs_serial_shift = 1'b0;
		end
		rdback(16'h0123, 16'h0234);
		mreset(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		prog(16'h03ff, 16'h0000);
		rdback(16'h03ff, 16'h0000);
	endtask : sc_defaults

	task automatic sc_std_fill();
		mreset(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
		prog(16'h0004, 16'h0008);
		chk("flags", flg, 36'h33);
		fill(1);
		chk("flags", flg, 36'h73);
		fill(3);
		chk("flags", flg, 36'h73);
		fill(1);
		chk("flags", flg, 36'h77);
		fill(507);
		chk("flags", flg, 36'h77);
		fill(1);
		chk("flags", flg, 36'h76);
		fill(502);
		chk("flags", flg, 36'h76);
		fill(1);
		chk("flags", flg, 36'h74);
		fill(7);
		chk("flags", flg, 36'h74);
		fill(1);
		chk("flags", flg, 36'h54);
		rd1();
		chk("data", data_out, wd(0));
		chk("flags", flg, 36'h74);
		fill(3);
		chk("wr_ready", {35'h0, wr_ready}, 36'h0);
		chk("flags", flg, 36'h54);
		for (int i = 1; i <= 11; i++)
		begin
			rd1();
			chk("data", data_out, wd(i));
			if (i == 10)
				chk("flags", flg, 36'h74);
		end
		chk("flags", flg, 36'h76);
	endtask : sc_std_fill

	task automatic sc_std_drain();
		mreset(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		prog(16'h0004, 16'h03fd);
		fill(5);
		chk("flags", flg, 36'h75);
		for (int i = 0; i < 5; i++)
		begin
			rd1();
			chk("data", data_out, wd(i));
			if (i == 0)
				chk("flags", flg, 36'h71);
			if (i == 2)
				chk("flags", flg, 36'h73);
		end
		chk("flags", flg, 36'h33);
		rd1();
		chk("data", data_out, wd(4));
		chk("flags", flg, 36'h33);
	endtask : sc_std_drain

	task automatic sc_fwft_fill();
		mreset(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
		prog(16'h0004, 16'h0008);
		fill(1);
		chk("flags", flg, 36'h23);
		chk("data", data_out, wd(0));
		fill(4);
		chk("flags", flg, 36'h23);
		fill(1);
		chk("flags", flg, 36'h27);
		fill(507);
		chk("flags", flg, 36'h27);
		fill(1);
		chk("flags", flg, 36'h26);
		fill(502);
		chk("flags", flg, 36'h26);
		fill(1);
		chk("flags", flg, 36'h24);
		fill(7);
		chk("flags", flg, 36'h24);
		fill(1);
		chk("flags", flg, 36'h2c);
		rd1();
		chk("data", data_out, wd(1));
		chk("flags", flg, 36'h24);
		fill(3);
		chk("wr_ready", {35'h0, wr_ready}, 36'h0);
		chk("flags", flg, 36'h2c);
	endtask : sc_fwft_fill

	task automatic sc_fwft_drain();
		mreset(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		prog(16'h0004, 16'h0008);
		fill(6);
		chk("flags", flg, 36'h27);
		for (int i = 1; i <= 6; i++)
		begin
			rd1();
			if (i < 6)
				chk("data", data_out, wd(i));
			if (i == 1)
				chk("flags", flg, 36'h23);
		end
		chk("flags", flg, 36'h33);
		rd1();
		chk("data", data_out, wd(5));
		chk("flags", flg, 36'h33);
	endtask : sc_fwft_drain

	// watchdog well past the expected run length
	initial
	begin
		#1200000;
		err_total++;
		give_verdict();
	end

	// reset, then the scenarios in turn
	initial
	begin
		tick(4);
		rst = 1'b0;
		tick(2);
		sc_defaults();
		sc_std_fill();
		sc_std_drain();
		sc_fwft_fill();
		sc_fwft_drain();
		give_verdict();
	end
endmodule : dffs_top_tb_top
